// File: rtl/rfsq_sequencer.sv
// rfsq_sequencer: transceiver state machine; calibrates, receives, transmits, acks.
// assumes: demodulated bytes arrive valid-only (no ready); modulator bytes go out valid/ready; frame filter answers per frame.
`timescale 1ns/100ps
// Behaviour
// - receive is only entered after a synthesizer calibration completes.
// - take the length byte, then count bytes until that length is reached.
// - after the last byte, check the frame check sequence and record pass or fail.
// - when enabled, send an ack frame after a good frame the filter accepts; never when disabled.
// - optional channel assessment before transmit; busy channel aborts transmit.
// - after the last transmitted byte, go to receive for the ack by itself.
// - move transmit queue data to modulator, demodulated data to receive queue.
// - events raise exceptions, routable to instruction triggers or general pins.
// - general pins set as inputs can trigger command strobes.
// - the frame filter's per-frame verdict is used by the sequencer.
// - drive analog receive and transmit power controls from the state.
module rfsq_sequencer #(
	parameter int DEPTH = rfsq_pkg::QUEUE_DEPTH
) (
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	input  wire logic                         strobeRxOn,
	input  wire logic                         strobeTxOn,
	input  wire logic                         strobeOff,
	input  wire logic [rfsq_pkg::GPIO_N-1:0]  gpioIn,
	input  wire logic [rfsq_pkg::GPIO_N-1:0]  gpioIsInput,
	input  wire logic [2*rfsq_pkg::GPIO_N-1:0] gpioStrobeSel,
	input  wire logic                         ccaEnable,
	input  wire logic                         autoAckEnable,
	input  wire logic                         channelClear,
	input  wire logic                         calDone,
	output logic                              calStart,
	input  wire logic [7:0]                   txqData,
	input  wire logic                         txqValid,
	output logic                              txqReady,
	output logic      [7:0]                   modData,
	output logic                              modValid,
	input  wire logic                         modReady,
	input  wire logic [7:0]                   demodData,
	input  wire logic                         demodValid,
	input  wire logic                         demodSfd,
	output logic      [7:0]                   rxqData,
	output logic                              rxqValid,
	input  wire logic                         rxqReady,
	output logic                              rxqFlush,
	input  wire logic                         filterAccept,
	output logic                              rxPowerUp,
	output logic                              txPowerUp,
	output logic                              fsPowerUp,
	output logic      [rfsq_pkg::EXC_W-1:0]   exceptions,
	input  wire logic [rfsq_pkg::EXC_W-1:0]   excToInstr,
	output logic                              instrTrigger,
	input  wire logic [rfsq_pkg::EXC_W-1:0]   excToGpio,
	output logic                              gpioIrq,
	output logic                              lastFcsOk,
	output logic                              demodOverflow
);
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		S_IDLE, S_CAL, S_RX_WAIT, S_RX_LEN, S_RX_DATA, S_RX_END,
		S_CCA, S_TX_LEN, S_TX_DATA, S_TURN, S_ACK
	} rfsq_state_t;

	typedef struct packed {
		rfsq_state_t                 fsm;
		logic                        afterCal;
		logic [7:0]                  len;
		logic [7:0]                  cnt;
		logic [15:0]                 fcs;
		logic [7:0]                  timer;
		logic                        txPending;
		logic                        fcsOk;
		logic                        overflow;
		logic [2:0]                  ackIdx;
		logic [rfsq_pkg::EXC_W-1:0]  exc;
		logic [rfsq_pkg::GPIO_N-1:0] gpioPrev;
	} rfsq_core_state_t;

	rfsq_core_state_t st_reg;
	rfsq_core_state_t st_next;

	function automatic logic [15:0] fcs_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ rfsq_pkg::FCS_POLY_REV) : (r >> 1);
		return r;
	endfunction : fcs_step

	// gpio strobe select code: 0 none, 1 rx on, 2 tx on, 3 off
	function automatic logic gpio_hits(input logic [rfsq_pkg::GPIO_N-1:0] rise,
		input logic [2*rfsq_pkg::GPIO_N-1:0] sel, input rfsq_pkg::rfsq_strobe_t which);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < rfsq_pkg::GPIO_N; i++)
			hit = hit | (rise[i] && sel[2*i +: 2] == which);
		return hit;
	endfunction : gpio_hits

	////////////////////////////////////////////////////////////////////////////
	logic [rfsq_pkg::GPIO_N-1:0] gpioRise;
	logic                        doRx;
	logic                        doTx;
	logic                        doOff;
	logic                        rxByte;
	logic                        rxTake;
	logic                        rxSpace;
	logic [7:0]                  ackByte;

	assign gpioRise = gpioIn & ~st_reg.gpioPrev & gpioIsInput;
	assign doOff = strobeOff || gpio_hits(gpioRise, gpioStrobeSel, rfsq_pkg::RFSQ_STRB_OFF);
	assign doRx  = strobeRxOn || gpio_hits(gpioRise, gpioStrobeSel, rfsq_pkg::RFSQ_STRB_RXON);
	assign doTx  = strobeTxOn || gpio_hits(gpioRise, gpioStrobeSel, rfsq_pkg::RFSQ_STRB_TXON);
	assign rxByte = demodValid;

	always_comb begin
		unique case (st_reg.ackIdx)
			3'd0:    ackByte = rfsq_pkg::ACK_LEN;
			3'd1:    ackByte = rfsq_pkg::ACK_FRAME_TYPE;
			default: ackByte = 8'h00;
		endcase
	end

	// only bytes of a started frame enter the queue
	assign rxTake   = rxByte && (st_reg.fsm == S_RX_LEN || st_reg.fsm == S_RX_DATA);
	assign rxqFlush = 1'b0;
	assign txqReady = modReady && (st_reg.fsm == S_TX_LEN || st_reg.fsm == S_TX_DATA);
	assign modData  = (st_reg.fsm == S_ACK) ? ackByte : txqData;
	assign modValid = (st_reg.fsm == S_ACK) || ((st_reg.fsm == S_TX_LEN || st_reg.fsm == S_TX_DATA) && txqValid);

	assign calStart  = st_reg.fsm == S_CAL && st_reg.timer == 8'h00;
	assign fsPowerUp = st_reg.fsm != S_IDLE;
	assign rxPowerUp = st_reg.fsm inside {S_RX_WAIT, S_RX_LEN, S_RX_DATA, S_RX_END, S_CCA};
	assign txPowerUp = st_reg.fsm inside {S_TX_LEN, S_TX_DATA, S_ACK};

	assign exceptions    = st_reg.exc;
	assign instrTrigger  = |(st_reg.exc & excToInstr);
	assign gpioIrq       = |(st_reg.exc & excToGpio);
	assign lastFcsOk     = st_reg.fcsOk;
	assign demodOverflow = st_reg.overflow;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next          = st_reg;
		st_next.exc      = '0;
		st_next.gpioPrev = gpioIn;
		if (rxTake && !rxSpace)
			st_next.overflow = 1'b1;      // modem cannot stall, so a byte is lost

		unique case (st_reg.fsm)
			S_IDLE: begin
				if (doRx || doTx) begin
					st_next.fsm   = S_CAL;
					st_next.timer = '0;
				end
			end
			S_CAL: begin
				st_next.timer = (st_reg.timer == 8'hff) ? st_reg.timer : st_reg.timer + 8'h01;
				if (calDone && st_reg.timer >= 8'(rfsq_pkg::CAL_CYCLES)) begin
					st_next.exc[rfsq_pkg::EXC_CAL_DONE] = 1'b1;
					st_next.fsm = S_RX_WAIT;
				end
			end
			S_RX_WAIT: begin
				if (st_reg.txPending) begin
					st_next.txPending = 1'b0;
					st_next.timer     = '0;
					st_next.fsm       = ccaEnable ? S_CCA : S_TX_LEN;
				end else if (demodSfd)
					st_next.fsm = S_RX_LEN;
			end
			S_RX_LEN: begin
				if (rxByte) begin
					st_next.len = demodData & rfsq_pkg::MAX_FRAME_LEN;
					st_next.cnt = '0;
					st_next.fcs = rfsq_pkg::FCS_INIT;
					st_next.fsm = S_RX_DATA;
				end
			end
			S_RX_DATA: begin
				if (rxByte) begin
					st_next.cnt = st_reg.cnt + 8'h01;
					st_next.fcs = fcs_step(st_reg.fcs, demodData);
					if (st_reg.cnt + 8'h01 >= st_reg.len)
						st_next.fsm = S_RX_END;
				end
			end
			S_RX_END: begin
				// residue of zero means the appended check sequence matched
				st_next.fcsOk = st_reg.fcs == 16'h0000;
				st_next.exc[rfsq_pkg::EXC_RX_DONE]    = 1'b1;
				st_next.exc[rfsq_pkg::EXC_RX_FCS_OK]  = st_reg.fcs == 16'h0000;
				st_next.exc[rfsq_pkg::EXC_RX_FCS_BAD] = st_reg.fcs != 16'h0000;
				st_next.exc[rfsq_pkg::EXC_FILT_REJ]   = !filterAccept;
				st_next.timer = '0;
				if (autoAckEnable && st_reg.fcs == 16'h0000 && filterAccept) begin
					st_next.ackIdx = '0;
					st_next.fsm    = S_TURN;
				end else
					st_next.fsm = S_RX_WAIT;
			end
			S_TURN: begin
				st_next.timer = st_reg.timer + 8'h01;
				if (st_reg.timer >= 8'(rfsq_pkg::TURN_CYCLES - 1))
					st_next.fsm = S_ACK;
			end
			S_ACK: begin
				if (modReady) begin
					st_next.ackIdx = st_reg.ackIdx + 3'd1;
					if (st_reg.ackIdx >= 3'(rfsq_pkg::ACK_LEN)) begin
						st_next.exc[rfsq_pkg::EXC_ACK_DONE] = 1'b1;
						st_next.fsm = S_RX_WAIT;
					end
				end
			end
			S_CCA: begin
				st_next.timer = st_reg.timer + 8'h01;
				if (!channelClear) begin
					st_next.exc[rfsq_pkg::EXC_CCA_FAIL] = 1'b1;
					st_next.fsm = S_RX_WAIT;
				end else if (st_reg.timer >= 8'(rfsq_pkg::CCA_CYCLES - 1))
					st_next.fsm = S_TX_LEN;
			end
			S_TX_LEN: begin
				if (txqValid && modReady) begin
					st_next.len = txqData & rfsq_pkg::MAX_FRAME_LEN;
					st_next.cnt = '0;
					st_next.fsm = S_TX_DATA;
				end
			end
			S_TX_DATA: begin
				if (txqValid && modReady) begin
					st_next.cnt = st_reg.cnt + 8'h01;
					if (st_reg.cnt + 8'h01 >= st_reg.len) begin
						st_next.exc[rfsq_pkg::EXC_TX_DONE] = 1'b1;
						st_next.fsm = S_RX_WAIT;
					end
				end
			end
		endcase

		// set after the case: a strobe in the cycle the pending one is taken is kept
		if (doTx)
			st_next.txPending = 1'b1;
		if (doOff) begin
			st_next.fsm       = S_IDLE;
			st_next.txPending = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_reg       <= '0;
			st_reg.fsm   <= S_IDLE;
		end else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// receive queue buffer: slack while the host is slow; off drops what is left
	rfsq_fifo #(
		.WIDTH (rfsq_pkg::DATA_W),
		.DEPTH (DEPTH)
	) u_rx_queue (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.flush    (doOff),
		.inData   (demodData),
		.inValid  (rxTake),
		.inReady  (rxSpace),
		.outData  (rxqData),
		.outValid (rxqValid),
		.outReady (rxqReady)
	);
endmodule : rfsq_sequencer

// File: rtl/rfsq_pkg.sv
// rfsq_pkg: constants and types shared by the radio frame sequencer and its queue.
// assumes: one core clock, synchronous active-high reset.
package rfsq_pkg;
	localparam int          QUEUE_DEPTH    = 16;
	localparam int          DATA_W         = 8;
	localparam logic [7:0]  MAX_FRAME_LEN  = 8'h7f;
	localparam logic [7:0]  ACK_LEN        = 8'h05;
	localparam logic [7:0]  ACK_FRAME_TYPE = 8'h02;
	localparam logic [7:0]  CRC_INIT       = 8'h00;
	localparam logic [15:0] FCS_INIT       = 16'h0000;
	localparam logic [15:0] FCS_POLY_REV   = 16'h8408;
	localparam int          CAL_CYCLES     = 12;
	localparam int          TURN_CYCLES    = 19;
	localparam int          CCA_CYCLES     = 128;
	localparam int          EXC_W          = 8;
	localparam int          EXC_RX_DONE    = 0;
	localparam int          EXC_RX_FCS_OK  = 1;
	localparam int          EXC_RX_FCS_BAD = 2;
	localparam int          EXC_TX_DONE    = 3;
	localparam int          EXC_CCA_FAIL   = 4;
	localparam int          EXC_CAL_DONE   = 5;
	localparam int          EXC_ACK_DONE   = 6;
	localparam int          EXC_FILT_REJ   = 7;
	localparam int          GPIO_N         = 6;

	typedef enum logic [1:0] {
		RFSQ_STRB_NONE,
		RFSQ_STRB_RXON,
		RFSQ_STRB_TXON,
		RFSQ_STRB_OFF
	} rfsq_strobe_t;
endpackage : rfsq_pkg

// File: rtl/rfsq_fifo.sv
// rfsq_fifo: flip-flop queue with valid/ready on both sides.
// assumes: single clock, synchronous reset; depth a power of two.
`timescale 1ns/100ps
module rfsq_fifo #(
	parameter int WIDTH = rfsq_pkg::DATA_W,
	parameter int DEPTH = rfsq_pkg::QUEUE_DEPTH
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wrPtr;
		logic [AW:0]                 rdPtr;
	} rfsq_fifo_state_t;

	rfsq_fifo_state_t st_reg;
	rfsq_fifo_state_t st_next;
	logic             isFull;
	logic             isEmpty;

	assign isEmpty  = st_reg.wrPtr == st_reg.rdPtr;
	assign isFull   = (st_reg.wrPtr[AW-1:0] == st_reg.rdPtr[AW-1:0]) && (st_reg.wrPtr[AW] != st_reg.rdPtr[AW]);
	assign inReady  = !isFull;
	assign outValid = !isEmpty;
	assign outData  = st_reg.mem[st_reg.rdPtr[AW-1:0]];

	always_comb begin
		st_next = st_reg;
		if (inValid && !isFull) begin
			st_next.mem[st_reg.wrPtr[AW-1:0]] = inData;
			st_next.wrPtr = st_reg.wrPtr + 1'b1;
		end
		if (outReady && !isEmpty)
			st_next.rdPtr = st_reg.rdPtr + 1'b1;
		if (flush) begin
			st_next.wrPtr = '0;
			st_next.rdPtr = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule : rfsq_fifo

// File: verification/rfsq_sequencer_chk.sv
// rfsq_sequencer_chk: port-level timing checks for the radio frame sequencer.
// assumes: bound to rfsq_sequencer; one clock, sync active-high reset.
`timescale 1ns/100ps
module rfsq_sequencer_chk #(
	parameter int DEPTH = rfsq_pkg::QUEUE_DEPTH
) (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        strobeRxOn,
	input wire logic        strobeOff,
	input wire logic [5:0]  gpioIn,
	input wire logic [5:0]  gpioIsInput,
	input wire logic [11:0] gpioStrobeSel,
	input wire logic        autoAckEnable,
	input wire logic        calStart,
	input wire logic        modValid,
	input wire logic [7:0]  demodData,
	input wire logic        demodValid,
	input wire logic [7:0]  rxqData,
	input wire logic        rxqValid,
	input wire logic        rxqReady,
	input wire logic        rxPowerUp,
	input wire logic        txPowerUp,
	input wire logic        fsPowerUp,
	input wire logic [7:0]  exceptions,
	input wire logic [7:0]  excToInstr,
	input wire logic        instrTrigger
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic idle;
	assign idle = !fsPowerUp && !rxPowerUp && !txPowerUp;
	////////////////////////////////////////////////////////////////
	// calibration lasts 12 cycles, so 8 quiet cycles is a safe floor
	property p_cal_rx; calStart |=> !rxPowerUp [*8]; endproperty
	a_cal_rx: assert property (p_cal_rx) else $error("rx up during cal");
	property p_rx_strobe; strobeRxOn && !strobeOff && idle |=> calStart && fsPowerUp; endproperty
	a_rx_strobe: assert property (p_rx_strobe) else $error("rx strobe skipped cal");
	property p_gpio; $rose(gpioIn[1]) && gpioIsInput[1] && gpioStrobeSel[3:2] == 2'h1 && !strobeOff && idle |=> calStart; endproperty
	a_gpio: assert property (p_gpio) else $error("pin strobe ignored");
	property p_off; strobeOff |=> idle; endproperty
	a_off: assert property (p_off) else $error("off left power up");
	property p_verdict; exceptions[1] || exceptions[2] |-> exceptions[0] && (exceptions[1] != exceptions[2]); endproperty
	a_verdict: assert property (p_verdict) else $error("bad fcs verdict");
	property p_no_ack; !autoAckEnable |-> !exceptions[6]; endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack while disabled");
	property p_ack; exceptions[1] && !exceptions[7] && autoAckEnable |-> ##[1:40] modValid; endproperty
	a_ack: assert property (p_ack) else $error("ack not started");
	property p_rxq_hold; rxqValid && !rxqReady && !strobeOff |=> rxqValid && $stable(rxqData); endproperty
	a_rxq_hold: assert property (p_rxq_hold) else $error("queued byte dropped");
	property p_mod_tx; modValid |-> txPowerUp && !rxPowerUp; endproperty
	a_mod_tx: assert property (p_mod_tx) else $error("modulator data off tx");
	property p_trig; instrTrigger == |(exceptions & excToInstr); endproperty
	a_trig: assert property (p_trig) else $error("trigger mask wrong");
endmodule : rfsq_sequencer_chk

bind rfsq_sequencer rfsq_sequencer_chk #(.DEPTH(DEPTH)) i_chk (.core_clk, .sys_rst, .strobeRxOn, .strobeOff,
	.gpioIn, .gpioIsInput, .gpioStrobeSel, .autoAckEnable, .calStart, .modValid, .demodData, .demodValid,
	.rxqData, .rxqValid, .rxqReady, .rxPowerUp, .txPowerUp, .fsPowerUp, .exceptions, .excToInstr, .instrTrigger);

// File: verification/rfsq_modem_model.sv
// rfsq_modem_model: synthesizer and modulator stand-in facing the sequencer.
// assumes: fed from the sequencer's power and modulator stream outputs.
`timescale 1ns/100ps
module rfsq_modem_model (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       fsPowerUp,
	input  wire logic       calStart,
	input  wire logic       slowMode,
	input  wire logic [7:0] modData,
	input  wire logic       modValid,
	output logic            calDone,
	output logic            modReady
);
	int         calCnt;
	logic [7:0] modLog[$];
	always @(posedge core_clk) begin
		if (sys_rst || calStart || !fsPowerUp)
			calCnt <= 0;
		else if (calCnt < rfsq_pkg::CAL_CYCLES)
			calCnt <= calCnt + 1;
		if (modValid && modReady)
			modLog.push_back(modData);
		// slow mode stalls every other beat
		modReady <= sys_rst ? 1'b0 : (slowMode ? !modReady : 1'b1);
	end
	assign calDone = (calCnt >= rfsq_pkg::CAL_CYCLES);
endmodule : rfsq_modem_model

// File: verification/rfsq_sequencer_tb.sv
// rfsq_sequencer_tb: self-checking bench for the radio frame sequencer.
// assumes: modem model on the far side; bench plays host, queues and demodulator.
`timescale 1ns/100ps
module rfsq_sequencer_tb;
	logic        core_clk = 1'b0, sys_rst = 1'b1, strobeRxOn = 1'b0, strobeTxOn = 1'b0, strobeOff = 1'b0;
	logic [5:0]  gpioIn = 6'h00, gpioIsInput = 6'h03;
	logic [11:0] gpioStrobeSel = 12'h007;
	logic        ccaEnable = 1'b0, autoAckEnable = 1'b1, channelClear = 1'b1, slowMode = 1'b0;
	logic        txqValid = 1'b0, demodValid = 1'b0, demodSfd = 1'b0, rxqReady = 1'b1, filterAccept = 1'b1;
	logic [7:0]  txqData = 8'h00, demodData = 8'h00, excToInstr = 8'h01, excToGpio = 8'h0c, excSeen = 8'h00;
	logic        calDone, calStart, txqReady, modValid, modReady, rxqValid, rxqFlush, rxPowerUp, txPowerUp;
	logic        fsPowerUp, instrTrigger, gpioIrq, lastFcsOk, demodOverflow;
	logic        irqSeen = 1'b0;
	logic [7:0]  modData, rxqData, exceptions;
	logic [7:0]  txBytes[$];
	int          error_cnt = 0, n_tests = 0, rxqCnt = 0;

	rfsq_sequencer i_dut (.core_clk, .sys_rst, .strobeRxOn, .strobeTxOn, .strobeOff, .gpioIn, .gpioIsInput,
		.gpioStrobeSel, .ccaEnable, .autoAckEnable, .channelClear, .calDone, .calStart, .txqData, .txqValid,
		.txqReady, .modData, .modValid, .modReady, .demodData, .demodValid, .demodSfd, .rxqData, .rxqValid,
		.rxqReady, .rxqFlush, .filterAccept, .rxPowerUp, .txPowerUp, .fsPowerUp, .exceptions, .excToInstr,
		.instrTrigger, .excToGpio, .gpioIrq, .lastFcsOk, .demodOverflow);
	rfsq_modem_model i_far (.core_clk, .sys_rst, .fsPowerUp, .calStart, .slowMode, .modData, .modValid,
		.calDone, .modReady);

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		excSeen |= exceptions;
		irqSeen |= gpioIrq;
		if (rxqValid === 1'b1)
			rxqCnt++;
		if (txqValid === 1'b1 && txqReady === 1'b1)
			void'(txBytes.pop_front());
		#1;
		txqValid = (txBytes.size() != 0);
		txqData = txqValid ? txBytes[0] : 8'h00;
	end
	////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk
	task automatic wait_exc(input int b, input int lim);
		for (int i = 0; i < lim && excSeen[b] !== 1'b1; i++)
			step(1);
	endtask : wait_exc
	// reflected crc, zero init: appending it low byte first leaves a zero residue
	function automatic logic [15:0] fcs_of(input logic [7:0] b[$]);
		logic [15:0] c = rfsq_pkg::FCS_INIT;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ rfsq_pkg::FCS_POLY_REV) : (c >> 1);
		end
		return c;
	endfunction : fcs_of
	task automatic wrap_up();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////
	task automatic t_rx_on();
		excSeen = 8'h00;
		strobeRxOn = 1'b1;
		step(1);
		strobeRxOn = 1'b0;
		chk(calStart === 1'b1 && fsPowerUp === 1'b1 && rxPowerUp === 1'b0, "no cal on rx strobe");
		wait_exc(rfsq_pkg::EXC_CAL_DONE, 60);
		chk(rxPowerUp === 1'b1 && excSeen[5] === 1'b1, "rx not up after cal");
	endtask : t_rx_on
	task automatic t_frame(input int n, input logic bad, input logic acc, input logic ack, input logic stall);
		logic [7:0]  fr[$];
		logic [7:0]  ackQ[$] = '{rfsq_pkg::ACK_LEN, rfsq_pkg::ACK_FRAME_TYPE, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [15:0] c;
		for (int i = 0; i < n; i++)
			fr.push_back(8'(i * 7 + 3));
		c = fcs_of(fr);
		fr.push_back(c[7:0] ^ {7'h00, bad});
		fr.push_back(c[15:8]);
		filterAccept = acc;
		rxqReady = !stall;
		i_far.modLog.delete();
		// a stray byte ahead of the frame start must be dropped
		demodValid = 1'b1;
		demodData = 8'hff;
		step(1);
		excSeen = 8'h00;
		rxqCnt = 0;
		demodValid = 1'b0;
		demodSfd = 1'b1;
		step(1);
		demodSfd = 1'b0;
		demodValid = 1'b1;
		demodData = 8'(n + 2);
		step(1);
		foreach (fr[i]) begin
			demodData = fr[i];
			step(1);
		end
		demodValid = 1'b0;
		step(6);
		chk(excSeen[2:0] === (bad ? 3'b101 : 3'b011), "fcs verdict");
		chk(lastFcsOk === !bad, "last fcs flag");
		chk(excSeen[7] === !acc, "filter verdict");
		chk(demodOverflow === stall, "overflow flag");
		if (!stall)
			chk(rxqCnt == n + 3, "receive byte count");
		wait_exc(rfsq_pkg::EXC_ACK_DONE, 100);
		chk(excSeen[6] === ack, "ack sent");
		if (ack)
			chk(i_far.modLog == ackQ, "ack bytes");
		rxqReady = 1'b1;
		step(2);
	endtask : t_frame
	task automatic t_tx(input logic cca, input logic clr, input logic slow);
		logic [7:0] sent[$] = '{8'h04, 8'ha5, 8'h5a, 8'h01, 8'hfe};
		txBytes = sent;
		ccaEnable = cca;
		channelClear = clr;
		slowMode = slow;
		excSeen = 8'h00;
		irqSeen = 1'b0;
		i_far.modLog.delete();
		strobeTxOn = 1'b1;
		step(1);
		strobeTxOn = 1'b0;
		wait_exc(clr ? 3 : 4, 400);
		step(3);
		chk(excSeen[4:3] === {!clr, clr}, "transmit outcome");
		chk(irqSeen === clr, "pin interrupt routing");
		if (clr)
			chk(i_far.modLog == sent, "transmit bytes");
		else
			chk(i_far.modLog.size() == 0, "sent on busy channel");
		chk(rxPowerUp === 1'b1 && txPowerUp === 1'b0, "not listening after tx");
		txBytes.delete();
		channelClear = 1'b1;
		step(2);
	endtask : t_tx
	task automatic t_gpio();
		gpioIn = 6'h01;
		step(3);
		chk(rxPowerUp === 1'b0 && fsPowerUp === 1'b0, "pin off strobe");
		gpioIn = 6'h00;
		step(1);
		excSeen = 8'h00;
		gpioIn = 6'h02;
		wait_exc(rfsq_pkg::EXC_CAL_DONE, 60);
		chk(rxPowerUp === 1'b1, "pin rx strobe");
		gpioIn = 6'h00;
		step(1);
		// pin 0 now starts a transmit; empty transmit queue parks it in the length state
		ccaEnable = 1'b0;
		gpioStrobeSel = 12'h006;
		gpioIn = 6'h01;
		step(3);
		chk(txPowerUp === 1'b1, "pin tx strobe");
		strobeOff = 1'b1;
		step(1);
		strobeOff = 1'b0;
		chk((rxPowerUp | txPowerUp | fsPowerUp) === 1'b0, "off strobe");
		step(2);
	endtask : t_gpio
	////////////////////////////////////////////////////////////////
	initial begin
		// generous bound: the whole sequence needs under a thousand cycles
		#100000;
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		chk((rxPowerUp | txPowerUp | fsPowerUp | modValid) === 1'b0 && exceptions === 8'h00, "reset state");
		t_rx_on();
		t_frame(3, 1'b0, 1'b1, 1'b1, 1'b0);
		t_frame(125, 1'b0, 1'b1, 1'b1, 1'b0);
		t_frame(3, 1'b1, 1'b1, 1'b0, 1'b0);
		t_frame(4, 1'b0, 1'b0, 1'b0, 1'b0);
		autoAckEnable = 1'b0;
		t_frame(20, 1'b0, 1'b1, 1'b0, 1'b1);
		autoAckEnable = 1'b1;
		t_tx(1'b0, 1'b1, 1'b0);
		t_tx(1'b1, 1'b1, 1'b1);
		t_tx(1'b1, 1'b0, 1'b0);
		t_gpio();
		wrap_up();
	end
endmodule : rfsq_sequencer_tb
